/* File: src/tpg_consts.svh */
// Register indices, field positions and reset values of the GPIO bank
`ifndef TPG_CONSTS_SVH
`define TPG_CONSTS_SVH

// Register indices; the APB byte address is four times the index
`define TPG_IDX_PA_DATA 4'h0
`define TPG_IDX_PA_DIR 4'h1
`define TPG_IDX_PA_OPT 4'h2
`define TPG_IDX_PB_DATA 4'h4
`define TPG_IDX_PB_DIR 4'h5
`define TPG_IDX_PB_OPT 4'h6
`define TPG_IDX_PC_DATA 4'h8
`define TPG_IDX_PC_DIR 4'h9
`define TPG_IDX_PC_OPT 4'ha
`define TPG_IDX_MISC 4'hc

// Reset values
`define TPG_REG_RESET 8'h00
`define TPG_POL_RESET 2'h0
`define TPG_IRQ_IDLE 1'b1

// Polarity field positions in misc_control_one
`define TPG_POL_A_LSB 3
`define TPG_POL_B_LSB 6
`define TPG_POL_W 2

`endif

/* File: src/tpg_pkg.sv */
// Types shared by the GPIO bank modules
`default_nettype none

package tpg_pkg;
    typedef logic [7:0] tpg_byte_type;
    typedef logic [3:0] tpg_idx_type;
    typedef enum logic [1:0] {
        TPG_POL_LOW_LEVEL = 2'h0,
        TPG_POL_RISE = 2'h1,
        TPG_POL_FALL = 2'h2,
        TPG_POL_BOTH = 2'h3
    } tpg_pol_type;
endpackage : tpg_pkg

`default_nettype wire

/* File: src/tpg_port_if.sv */
// Bundle between the register core and one port's pad logic
`default_nettype none

interface tpg_port_if;
    import tpg_pkg::*;
    tpg_byte_type latch;
    tpg_byte_type dir;
    tpg_byte_type opt;
    tpg_byte_type alt_en;
    tpg_byte_type alt_val;
    tpg_byte_type alt_pp;
    tpg_byte_type pin_in;
    tpg_byte_type pin_out;
    tpg_byte_type pin_oe;
    tpg_byte_type pull_up;
    tpg_byte_type high_side;
    tpg_byte_type rd_val;
    logic irq_lvl;
    modport ctrl (
        output latch, dir, opt, alt_en, alt_val, alt_pp, pin_in,
        input pin_out, pin_oe, pull_up, high_side, rd_val, irq_lvl
    );
    modport pad (
        input latch, dir, opt, alt_en, alt_val, alt_pp, pin_in,
        output pin_out, pin_oe, pull_up, high_side, rd_val, irq_lvl
    );
endinterface : tpg_port_if

`default_nettype wire

/* File: src/tpg_port.sv */
// Pad control, readback and interrupt level for one port
`default_nettype none

module tpg_port #(
    parameter int W = 8,
    parameter bit HAS_IRQ = 1'b1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    tpg_port_if.pad port_bus
);
    import tpg_pkg::*;

    // Bits above W belong to no pin
    localparam tpg_byte_type USED = tpg_byte_type'((16'h1 << W) - 16'h1);

    tpg_byte_type out_mode;
    tpg_byte_type push_pull;
    tpg_byte_type drive_val;
    tpg_byte_type irq_en;

    // Alternate output wins over the port registers
    assign out_mode = (port_bus.alt_en | port_bus.dir) & USED; // RQ1 RQ10 RQ22
    assign push_pull = (port_bus.alt_en & port_bus.alt_pp)
        | (~port_bus.alt_en & port_bus.opt); // RQ10 RQ21
    assign drive_val = (port_bus.alt_en & port_bus.alt_val)
        | (~port_bus.alt_en & port_bus.latch); // RQ5
    // Pull-up input doubles as interrupt enable, never in output mode
    assign irq_en = HAS_IRQ ? (~out_mode & port_bus.opt & USED)
        : 8'h00; // RQ6 RQ8 RQ17
    // Enabled pins are wire-ANDed: one held low masks the rest
    assign port_bus.irq_lvl = &(port_bus.pin_in | ~irq_en); // RQ9
    // Pins read as seen when the dir bit is 0, latch when it is 1
    assign port_bus.rd_val = (port_bus.dir & port_bus.latch)
        | (~port_bus.dir & port_bus.pin_in); // RQ3 RQ11

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            port_bus.pin_oe <= 8'h00;
            port_bus.pin_out <= 8'h00;
            port_bus.high_side <= 8'h00;
            port_bus.pull_up <= 8'h00;
        end else if (ce) begin
            // Open drain drives only the low level
            port_bus.pin_oe <= out_mode & (push_pull | ~drive_val); // RQ5 RQ21
            port_bus.pin_out <= out_mode & push_pull & drive_val; // RQ5
            port_bus.high_side <= out_mode & push_pull; // RQ18
            port_bus.pull_up <= ~out_mode & port_bus.opt & USED; // RQ16 RQ18
        end
    end

    a_pad_exclusive: assert property (@(posedge ref_clk) // RQ18
        disable iff (!resetn)
        (port_bus.pull_up & port_bus.high_side) == 8'h00)
        else $error("pull-up and high-side buffer both on");

endmodule : tpg_port

`default_nettype wire

/* File: src/tpg_bank.sv */
// Three-port GPIO bank with APB register access
//
// Local design decision: the APB interface to the registers.
`include "tpg_consts.svh"
`default_nettype none

//Contract
//RQ1: Direction bit 0 makes the pin input, 1 makes it output.
//RQ2: Reset clears all data, direction and option registers.
//RQ3: Data read gives latch for outputs, live pin for inputs.
//RQ4: Data writes always update the latch, whatever the direction.
//RQ5: An output pin drives its latch value.
//RQ6: Pins in output mode never raise interrupts.
//RQ7: Input-with-interrupt pins raise requests per the polarity setting.
//RQ8: Each pin requests alone; each line serves a fixed pin group.
//RQ9: Group requests are ORed; a low enabled pin masks the others.
//RQ10: Peripheral output overrides registers, forcing output and its drive.
//RQ11: A pin feeding a peripheral stays readable through data reads.
//RQ12: Software leaves bidirectional peripheral pins configured as input.
//RQ13: Software enables no alternate function on interrupt inputs.
//RQ14: Software sets analog pins to floating input first.
//RQ15: Software writes the latch before turning a pin to output.
//RQ16: In input mode option 0 is floating, 1 is pull-up.
//RQ17: Pull-up enables interrupts on ports A and B, not C.
//RQ18: Pull-up and high-side buffer are enabled per the pad encoding.
//RQ19: Polarity 00 low level, 01 rising, 10 falling, 11 both.
//RQ20: Port A feeds group A line, port B group B; own polarity.
//RQ21: In output mode option 0 is open drain, 1 push-pull.
//RQ22: Port C has pins 0 to 5; upper bits drive nothing.
module tpg_bank #(
    parameter int ADDR_W = 12,
    parameter int PC_W = 6
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tpg_pkg::tpg_byte_type pa_pin_in,
    output tpg_pkg::tpg_byte_type pa_pin_out,
    output tpg_pkg::tpg_byte_type pa_pin_oe,
    output tpg_pkg::tpg_byte_type pa_pull_up,
    output tpg_pkg::tpg_byte_type pa_high_side,
    input wire tpg_pkg::tpg_byte_type pa_alt_en,
    input wire tpg_pkg::tpg_byte_type pa_alt_val,
    input wire tpg_pkg::tpg_byte_type pa_alt_pp,
    input wire tpg_pkg::tpg_byte_type pb_pin_in,
    output tpg_pkg::tpg_byte_type pb_pin_out,
    output tpg_pkg::tpg_byte_type pb_pin_oe,
    output tpg_pkg::tpg_byte_type pb_pull_up,
    output tpg_pkg::tpg_byte_type pb_high_side,
    input wire tpg_pkg::tpg_byte_type pb_alt_en,
    input wire tpg_pkg::tpg_byte_type pb_alt_val,
    input wire tpg_pkg::tpg_byte_type pb_alt_pp,
    input wire logic [PC_W-1:0] pc_pin_in,
    output logic [PC_W-1:0] pc_pin_out,
    output logic [PC_W-1:0] pc_pin_oe,
    output logic [PC_W-1:0] pc_pull_up,
    output logic [PC_W-1:0] pc_high_side,
    input wire logic [PC_W-1:0] pc_alt_en,
    input wire logic [PC_W-1:0] pc_alt_val,
    input wire logic [PC_W-1:0] pc_alt_pp,
    output logic group_a_irq_line,
    output logic group_b_irq_line
);
    import tpg_pkg::*;

    localparam tpg_idx_type DATA_IDX [3] =
        '{`TPG_IDX_PA_DATA, `TPG_IDX_PB_DATA, `TPG_IDX_PC_DATA};
    localparam tpg_idx_type DIR_IDX [3] =
        '{`TPG_IDX_PA_DIR, `TPG_IDX_PB_DIR, `TPG_IDX_PC_DIR};
    localparam tpg_idx_type OPT_IDX [3] =
        '{`TPG_IDX_PA_OPT, `TPG_IDX_PB_OPT, `TPG_IDX_PC_OPT};

    tpg_byte_type data_reg [3];
    tpg_byte_type dir_reg [3];
    tpg_byte_type opt_reg [3];
    tpg_pol_type pol_reg [2];
    logic [31:0] prdata_reg;

    tpg_byte_type pin_in_arr [3];
    tpg_byte_type alt_en_arr [3];
    tpg_byte_type alt_val_arr [3];
    tpg_byte_type alt_pp_arr [3];
    tpg_byte_type rd_val_arr [3];

    tpg_idx_type idx;
    logic addr_ok;
    logic hit;
    logic setup_rd;
    logic wr_en;
    logic [31:0] rd_next;

    tpg_port_if pif [3] ();

    // Port C has only PC_W pins; upper inputs read as zero
    assign pin_in_arr[0] = pa_pin_in;
    assign pin_in_arr[1] = pb_pin_in;
    assign pin_in_arr[2] = tpg_byte_type'(pc_pin_in); // RQ22
    assign alt_en_arr[0] = pa_alt_en;
    assign alt_en_arr[1] = pb_alt_en;
    assign alt_en_arr[2] = tpg_byte_type'(pc_alt_en);
    assign alt_val_arr[0] = pa_alt_val;
    assign alt_val_arr[1] = pb_alt_val;
    assign alt_val_arr[2] = tpg_byte_type'(pc_alt_val);
    assign alt_pp_arr[0] = pa_alt_pp;
    assign alt_pp_arr[1] = pb_alt_pp;
    assign alt_pp_arr[2] = tpg_byte_type'(pc_alt_pp);

    assign pa_pin_out = pif[0].pin_out;
    assign pa_pin_oe = pif[0].pin_oe;
    assign pa_pull_up = pif[0].pull_up;
    assign pa_high_side = pif[0].high_side;
    assign pb_pin_out = pif[1].pin_out;
    assign pb_pin_oe = pif[1].pin_oe;
    assign pb_pull_up = pif[1].pull_up;
    assign pb_high_side = pif[1].high_side;
    assign pc_pin_out = pif[2].pin_out[PC_W-1:0];
    assign pc_pin_oe = pif[2].pin_oe[PC_W-1:0];
    assign pc_pull_up = pif[2].pull_up[PC_W-1:0];
    assign pc_high_side = pif[2].high_side[PC_W-1:0];

    // APB decode; clock enable low stretches the access phase
    assign idx = paddr[5:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:6] == '0);
    assign pready = ce;
    assign setup_rd = psel && !penable && !pwrite && ce;
    assign wr_en = psel && penable && pwrite && pready && hit && pstrb[0];
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_reg;

    always_comb begin
        hit = 1'b0;
        rd_next = 32'h0000_0000;
        for (int p = 0; p < 3; p++) begin
            if (idx == DATA_IDX[p]) begin
                hit = 1'b1;
                rd_next = {24'h00_0000, rd_val_arr[p]}; // RQ3 RQ11
            end
            if (idx == DIR_IDX[p]) begin
                hit = 1'b1;
                rd_next = {24'h00_0000, dir_reg[p]};
            end
            if (idx == OPT_IDX[p]) begin
                hit = 1'b1;
                rd_next = {24'h00_0000, opt_reg[p]};
            end
        end
        if (idx == `TPG_IDX_MISC) begin
            hit = 1'b1;
            rd_next[`TPG_POL_A_LSB +: `TPG_POL_W] = pol_reg[0];
            rd_next[`TPG_POL_B_LSB +: `TPG_POL_W] = pol_reg[1];
        end
        if (!addr_ok) begin
            hit = 1'b0;
            rd_next = 32'h0000_0000;
        end
    end

    // Read data caught in setup so the access phase needs no wait
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_reg <= rd_next;
        end
    end

    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_port
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    data_reg[p] <= `TPG_REG_RESET; // RQ2
                end else if (ce && wr_en && idx == DATA_IDX[p]) begin
                    // Taken even while the pin is an input
                    data_reg[p] <= pwdata[7:0]; // RQ4 RQ15
                end
            end

            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    dir_reg[p] <= `TPG_REG_RESET; // RQ2
                end else if (ce && wr_en && idx == DIR_IDX[p]) begin
                    dir_reg[p] <= pwdata[7:0]; // RQ1
                end
            end

            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    opt_reg[p] <= `TPG_REG_RESET; // RQ2
                end else if (ce && wr_en && idx == OPT_IDX[p]) begin
                    opt_reg[p] <= pwdata[7:0]; // RQ16 RQ21
                end
            end

            assign pif[p].latch = data_reg[p];
            assign pif[p].dir = dir_reg[p];
            assign pif[p].opt = opt_reg[p];
            assign pif[p].alt_en = alt_en_arr[p];
            assign pif[p].alt_val = alt_val_arr[p];
            assign pif[p].alt_pp = alt_pp_arr[p];
            assign pif[p].pin_in = pin_in_arr[p];
            assign rd_val_arr[p] = pif[p].rd_val;

            tpg_port #(
                .W(p == 2 ? PC_W : 8),
                .HAS_IRQ(p != 2) // RQ17
            ) u_port (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .ce(ce),
                .port_bus(pif[p])
            );
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pol_reg[0] <= tpg_pol_type'(`TPG_POL_RESET);
            pol_reg[1] <= tpg_pol_type'(`TPG_POL_RESET);
        end else if (ce && wr_en && idx == `TPG_IDX_MISC) begin
            pol_reg[0] <= tpg_pol_type'(pwdata[`TPG_POL_A_LSB +: `TPG_POL_W]);
            pol_reg[1] <= tpg_pol_type'(pwdata[`TPG_POL_B_LSB +: `TPG_POL_W]);
        end
    end

    // Group A from port A, group B from port B
    generate
        for (p = 0; p < 2; p++) begin : g_irq
            logic lvl;
            logic prev_reg;
            logic irq_reg;
            logic irq_next;
            assign lvl = pif[p].irq_lvl; // RQ20
            always_comb begin
                case (pol_reg[p])
                    TPG_POL_LOW_LEVEL: irq_next = !lvl; // RQ19
                    TPG_POL_RISE: irq_next = lvl && !prev_reg; // RQ19
                    TPG_POL_FALL: irq_next = !lvl && prev_reg; // RQ19
                    TPG_POL_BOTH: irq_next = lvl ^ prev_reg; // RQ19
                    default: irq_next = 1'b0;
                endcase
            end
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    prev_reg <= `TPG_IRQ_IDLE;
                    irq_reg <= 1'b0;
                end else if (ce) begin
                    prev_reg <= lvl;
                    irq_reg <= irq_next; // RQ7 RQ8
                end
            end
        end
    endgenerate

    assign group_a_irq_line = g_irq[0].irq_reg;
    assign group_b_irq_line = g_irq[1].irq_reg;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_reset_clear: assert property ($rose(resetn) |-> // RQ2
        dir_reg[0] == 8'h00 && opt_reg[1] == 8'h00 && data_reg[2] == 8'h00)
        else $error("registers not zero after reset");

    a_input_no_drive: assert property (ce && !pa_alt_en[0] // RQ1
        && !dir_reg[0][0] |=> !pa_pin_oe[0] && !pa_high_side[0])
        else $error("input pin is driven");

    a_read_mix: assert property (setup_rd && addr_ok // RQ3
        && idx == `TPG_IDX_PA_DATA |=> prdata[7:0] ==
        (($past(dir_reg[0]) & $past(data_reg[0]))
        | (~$past(dir_reg[0]) & $past(pa_pin_in))))
        else $error("data read mixes latch and pins wrongly");

    a_write_latch: assert property (wr_en && ce // RQ4
        && idx == `TPG_IDX_PA_DATA |=> data_reg[0] == $past(pwdata[7:0]))
        else $error("data write not taken");

    a_push_pull_out: assert property (ce && dir_reg[0][4] // RQ5
        && opt_reg[0][4] && !pa_alt_en[4] |=> pa_pin_oe[4]
        && pa_pin_out[4] == $past(data_reg[0][4]))
        else $error("push-pull pin does not drive latch");

    a_out_no_irq: assert property (ce // RQ6
        && pol_reg[0] == TPG_POL_LOW_LEVEL && dir_reg[0][0] && opt_reg[0][0]
        && (pa_pin_in | dir_reg[0] | ~opt_reg[0]) == 8'hff
        |=> !group_a_irq_line)
        else $error("output pin raised interrupt");

    a_level_irq: assert property (ce // RQ7
        && pol_reg[0] == TPG_POL_LOW_LEVEL && opt_reg[0][0]
        && !dir_reg[0][0] && !pa_alt_en[0] && !pa_pin_in[0]
        |=> group_a_irq_line)
        else $error("low level did not raise group A");

    a_group_b_level: assert property (ce // RQ20
        && pol_reg[1] == TPG_POL_LOW_LEVEL && opt_reg[1][3]
        && !dir_reg[1][3] && !pb_alt_en[3] && !pb_pin_in[3]
        |=> group_b_irq_line)
        else $error("low level did not raise group B");

    a_rise_pulse: assert property (ce && group_b_irq_line // RQ19
        && pol_reg[1] == TPG_POL_RISE |=> !group_b_irq_line)
        else $error("rising edge request longer than one cycle");

    a_alt_override: assert property (ce && pa_alt_en[2] // RQ10
        && pa_alt_pp[2] |=> pa_pin_oe[2]
        && pa_pin_out[2] == $past(pa_alt_val[2]))
        else $error("alternate output not applied");

    a_open_drain_high: assert property (ce && dir_reg[0][7] // RQ21
        && !opt_reg[0][7] && !pa_alt_en[7] && data_reg[0][7]
        |=> !pa_pin_oe[7])
        else $error("open drain drove a high level");

    a_unmapped_err: assert property (psel && penable && !hit
        |-> pslverr ##1 (dir_reg[0] == $past(dir_reg[0])
        && opt_reg[0] == $past(opt_reg[0])))
        else $error("unmapped access flagged wrongly or took effect");

    a_freeze_state: assert property (!ce |=> $stable(dir_reg[0])
        && $stable(data_reg[0]) && $stable(pa_pin_oe)
        && $stable(group_a_irq_line))
        else $error("state changed while clock enable low");

    a_pull_up_input: assert property (ce && !dir_reg[2][0] // RQ16
        && opt_reg[2][0] && !pc_alt_en[0] |=> pc_pull_up[0])
        else $error("pull-up input not enabled");

    c_write_dir: cover property (wr_en && ce && idx == `TPG_IDX_PA_DIR);
    c_irq_a: cover property ($rose(group_a_irq_line));
    c_irq_b_both: cover property (pol_reg[1] == TPG_POL_BOTH
        && group_b_irq_line);
    c_alt_drive: cover property (pa_alt_en != 8'h00 && pa_pin_oe != 8'h00);
    c_freeze: cover property (!ce && psel && penable);

endmodule : tpg_bank

`default_nettype wire

/* File: sim/tpg_pin_model.sv */
// Pin-level model of pads, pull-ups and outside sources
`default_nettype none

module tpg_pin_model #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] pull_up,
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    output logic [W-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] float_reg = '0;
    // Undriven pins wander, so a floating level is never trusted
    always @(posedge ref_clk) begin
        float_reg <= ~float_reg;
    end
    // Pad driver wins, then the outside source, then the pull-up
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pull_up[i]) pin_in[i] = 1'b1;
            else pin_in[i] = float_reg[i];
        end
    end
endmodule : tpg_pin_model

`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the three-port GPIO bank
`include "tpg_consts.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tpg_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, ia, ib, ce = 1'b1;
    logic [7:0] a_in, a_out, a_oe, a_pu, a_hs, b_in, b_out, b_oe, b_pu, b_hs;
    logic [5:0] c_in, c_out, c_oe, c_pu, c_hs;
    logic [7:0] a_ev = 8'h5a, a_ee = 8'hff, b_ev = 8'hc3, b_ee = 8'hff;
    logic [5:0] c_ev = 6'h21, c_ee = 6'h3f;
    logic [7:0] a_ae = 8'h00, a_av = 8'h00, a_ap = 8'h00;
    logic [7:0] b_ae = 8'h00, b_av = 8'h00, b_ap = 8'h00;
    logic [5:0] c_ae = 6'h00, c_av = 6'h00, c_ap = 6'h00;
    int num_errors = 0;
    int n_compared = 0;

    always #4 ref_clk = ~ref_clk;

    tpg_bank tpg_bank_inst (
        .ref_clk(ref_clk), .resetn(resetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pa_pin_in(a_in), .pa_pin_out(a_out),
        .pa_pin_oe(a_oe), .pa_pull_up(a_pu), .pa_high_side(a_hs),
        .pa_alt_en(a_ae), .pa_alt_val(a_av), .pa_alt_pp(a_ap),
        .pb_pin_in(b_in), .pb_pin_out(b_out), .pb_pin_oe(b_oe),
        .pb_pull_up(b_pu), .pb_high_side(b_hs), .pb_alt_en(b_ae),
        .pb_alt_val(b_av), .pb_alt_pp(b_ap), .pc_pin_in(c_in),
        .pc_pin_out(c_out), .pc_pin_oe(c_oe), .pc_pull_up(c_pu),
        .pc_high_side(c_hs), .pc_alt_en(c_ae), .pc_alt_val(c_av),
        .pc_alt_pp(c_ap), .group_a_irq_line(ia), .group_b_irq_line(ib));
    tpg_pin_model #(.W(8)) pm_a (.ref_clk(ref_clk), .pin_out(a_out),
        .pin_oe(a_oe), .pull_up(a_pu), .ext_val(a_ev), .ext_en(a_ee),
        .pin_in(a_in));
    tpg_pin_model #(.W(8)) pm_b (.ref_clk(ref_clk), .pin_out(b_out),
        .pin_oe(b_oe), .pull_up(b_pu), .ext_val(b_ev), .ext_en(b_ee),
        .pin_in(b_in));
    tpg_pin_model #(.W(6)) pm_c (.ref_clk(ref_clk), .pin_out(c_out),
        .pin_oe(c_oe), .pull_up(c_pu), .ext_val(c_ev), .ext_en(c_ee),
        .pin_in(c_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Holds the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [3:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {6'h00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [3:0] idx, input logic [7:0] v);
        logic [31:0] d;
        logic e;
        apb(1'b1, idx, v, d, e);
        chk(e, 1'b0);
    endtask : wr

    task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        logic e;
        apb(1'b0, idx, 8'h00, d, e);
        chk(d, exp);
        chk(e, 1'b0);
    endtask : rdc

    // Pads follow a register one edge after the write lands
    task automatic settle;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : settle

    task automatic cnt(input logic grp_b, input int exp);
        int n = 0;
        repeat (6) begin
            @(negedge ref_clk);
            if ((grp_b ? ib : ia) === 1'b1) n++;
        end
        chk(n, exp);
    endtask : cnt

    task automatic t_reset;
        logic [3:0] regs [7] = '{`TPG_IDX_PA_DIR, `TPG_IDX_PA_OPT,
            `TPG_IDX_PB_DIR, `TPG_IDX_PB_OPT, `TPG_IDX_PC_DIR,
            `TPG_IDX_PC_OPT, `TPG_IDX_MISC};
        foreach (regs[i]) rdc(regs[i], 8'h00);
        rdc(`TPG_IDX_PA_DATA, 8'h5a);
        rdc(`TPG_IDX_PB_DATA, 8'hc3);
        rdc(`TPG_IDX_PC_DATA, 8'h21);
        chk({a_oe, b_oe, c_oe}, 32'h0);
        chk({a_pu, b_pu, c_pu}, 32'h0);
        chk({ia, ib}, 2'b00);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_data;
        wr(`TPG_IDX_PA_DATA, 8'ha5);
        rdc(`TPG_IDX_PA_DATA, 8'h5a);
        wr(`TPG_IDX_PA_OPT, 8'hff);
        wr(`TPG_IDX_PA_DIR, 8'hf0);
        rdc(`TPG_IDX_PA_DATA, 8'haa);
        settle;
        chk(a_oe, 8'hf0);
        chk(a_out, 8'ha0);
        chk(a_hs, 8'hf0);
        chk(a_pu, 8'h0f);
        wr(`TPG_IDX_PA_OPT, 8'h00);
        settle;
        chk(a_oe, 8'h50);
        chk({a_out, a_hs}, 16'h0000);
        $display("t_data done");
    endtask : t_data

    task automatic t_portc;
        wr(`TPG_IDX_PC_DATA, 8'hff);
        wr(`TPG_IDX_PC_OPT, 8'hff);
        wr(`TPG_IDX_PC_DIR, 8'hff);
        settle;
        chk({c_out, c_oe}, 12'hfff);
        chk(c_hs, 6'h3f);
        rdc(`TPG_IDX_PC_DATA, 8'hff);
        wr(`TPG_IDX_PC_DIR, 8'h00);
        settle;
        chk(c_pu, 6'h3f);
        @(posedge ref_clk);
        c_ev <= 6'h20;
        cnt(1'b0, 0);
        cnt(1'b1, 0);
        $display("t_portc done");
    endtask : t_portc

    task automatic t_irq_a;
        @(posedge ref_clk);
        a_ev <= 8'hff;
        wr(`TPG_IDX_PA_DIR, 8'h00);
        wr(`TPG_IDX_PA_OPT, 8'h03);
        settle;
        cnt(1'b0, 0);
        @(posedge ref_clk);
        a_ev <= 8'hfe;
        cnt(1'b0, 5);
        @(posedge ref_clk);
        a_ev <= 8'hfc;
        cnt(1'b0, 6);
        @(posedge ref_clk);
        a_ev <= 8'hfe;
        cnt(1'b0, 6);
        cnt(1'b1, 0);
        wr(`TPG_IDX_PA_DATA, 8'h00);
        wr(`TPG_IDX_PA_DIR, 8'h01);
        settle;
        cnt(1'b0, 0);
        wr(`TPG_IDX_PA_OPT, 8'h00);
        wr(`TPG_IDX_PA_DIR, 8'h00);
        $display("t_irq_a done");
    endtask : t_irq_a

    task automatic t_irq_b;
        int fall_n [4] = '{5, 0, 1, 1};
        int rise_n [4] = '{1, 1, 0, 1};
        @(posedge ref_clk);
        b_ev <= 8'hff;
        wr(`TPG_IDX_PB_OPT, 8'h08);
        for (int p = 0; p < 4; p++) begin
            wr(`TPG_IDX_MISC, {p[1:0], 6'h00});
            rdc(`TPG_IDX_MISC, {p[1:0], 6'h00});
            settle;
            chk(b_pu, 8'h08);
            @(posedge ref_clk);
            b_ev <= 8'hf7;
            cnt(1'b1, fall_n[p]);
            chk(ia, 1'b0);
            @(posedge ref_clk);
            b_ev <= 8'hff;
            cnt(1'b1, rise_n[p]);
        end
        wr(`TPG_IDX_MISC, 8'h00);
        wr(`TPG_IDX_PB_OPT, 8'h00);
        $display("t_irq_b done");
    endtask : t_irq_b

    task automatic t_alt;
        @(posedge ref_clk);
        {a_ae, a_av, a_ap} <= {3{8'h04}};
        {b_ae, c_ae} <= {8'h04, 6'h04};
        settle;
        chk({a_oe, a_out, a_hs}, 24'h040404);
        chk({b_oe, c_oe}, 14'h0104);
        chk({b_out, b_hs}, 16'h0000);
        @(posedge ref_clk);
        {a_av, a_ap} <= 16'h0000;
        settle;
        chk({a_oe, a_out, a_hs}, 24'h040000);
        @(posedge ref_clk);
        // Input-only use keeps the pin floating input
        {a_ae, b_ae, c_ae} <= 22'h0;
        a_ev <= 8'h69;
        settle;
        rdc(`TPG_IDX_PA_DATA, 8'h69);
        $display("t_alt done");
    endtask : t_alt

    task automatic t_unmapped;
        logic [31:0] d;
        logic e;
        apb(1'b1, 4'h3, 8'hff, d, e);
        chk(e, 1'b1);
        apb(1'b0, 4'h3, 8'h00, d, e);
        chk(d, 32'h0);
        chk(e, 1'b1);
        rdc(`TPG_IDX_PA_OPT, 8'h00);
        $display("t_unmapped done");
    endtask : t_unmapped

    // A write started with clock enable low waits; nothing moves meanwhile
    task automatic t_freeze;
        @(posedge ref_clk);
        ce <= 1'b0;
        fork
            wr(`TPG_IDX_PA_DIR, 8'h0f);
            begin
                repeat (4) @(posedge ref_clk);
                @(negedge ref_clk);
                chk(a_oe, 8'h00);
                @(posedge ref_clk);
                ce <= 1'b1;
            end
        join
        rdc(`TPG_IDX_PA_DIR, 8'h0f);
        wr(`TPG_IDX_PA_DIR, 8'h00);
        $display("t_freeze done");
    endtask : t_freeze

    task automatic tally_and_finish;
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset;
        t_data;
        t_portc;
        t_irq_a;
        t_irq_b;
        t_alt;
        t_unmapped;
        t_freeze;
        tally_and_finish;
    end

    // Whole run needs a few hundred cycles; this bounds a hang
    initial begin
        #200000;
        num_errors++;
        tally_and_finish;
    end
endmodule : tb_top

`default_nettype wire
